// >>> core/nsx_dir_bank.sv
// Purpose: Port direction registers and the second option register
// Assumes: Load strobe and selector come from the execute logic on the same clock
// Notes:   Selectors other than 5, 6 and 7 load nothing
`timescale 1ns/1ps
module nsx_dir_bank
   import nsx_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Link to execute logic
   nsx_dir_if.bank   dif
);

   logic [7:0] dir_a_r;
   logic [7:0] dir_b_r;
   logic [7:0] opt2_r;
   wire        ld_a;
   wire        ld_b;
   wire        ld_o;

   assign ld_a = dif.ld && (dif.sel == SEL_PORT_A);
   assign ld_b = dif.ld && (dif.sel == SEL_PORT_B);
   assign ld_o = dif.ld && (dif.sel == SEL_SECOND_OPTION_REGISTER);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dir_a_r <= DIR_RST;
         dir_b_r <= DIR_RST;
         opt2_r  <= OPT2_RST;
      end
      else
      begin
         if (ld_a)
            dir_a_r <= dif.data;
         if (ld_b)
            dir_b_r <= dif.data;
         if (ld_o)
            opt2_r <= dif.data;
      end
   end

   assign dif.dir_a = dir_a_r;
   assign dif.dir_b = dir_b_r;
   assign dif.opt2  = opt2_r;

endmodule : nsx_dir_bank

// >>> core/nsx_dir_if.sv
// Purpose: Carrier between the execute logic and the direction register bank
// Assumes: One clock domain
// Notes:   Load strobe is a one-cycle pulse
`timescale 1ns/1ps
interface nsx_dir_if;
   logic       ld;
   logic [2:0] sel;
   logic [7:0] data;
   logic [7:0] dir_a;
   logic [7:0] dir_b;
   logic [7:0] opt2;

   modport ctrl (output ld, output sel, output data, input dir_a, input dir_b, input opt2);
   modport bank (input ld, input sel, input data, output dir_a, output dir_b, output opt2);
endinterface : nsx_dir_if

// >>> core/nsx_exec.sv
// Purpose: Decode and execute of nibble swap, register xor, literal xor and direction load
// Assumes: File register read data returns combinationally for FILE_RADDR in the same cycle
// Notes:   Every instruction completes in the cycle it is presented; results land at that edge
//
// Notes on behaviour
// - Nibble swap exchanges the two halves of the file register, flags untouched.
// - Nibble swap result goes to W when destination bit is 0, else file.
// - Direction load copies W into the direction register picked by low opcode bits.
// - Direction load with selector 7 writes the second option register instead.
// - Register xor combines W and file, routes by destination bit, updates zero only.
`timescale 1ns/1ps
module nsx_exec
   import nsx_pkg::*;
(
   // Clock and reset
   input  wire logic                REF_CLK,
   input  wire logic                SYS_RST,
   // Instruction from fetch
   input  wire logic [INSTR_W-1:0]  INSTR,
   input  wire logic                INSTR_VALID,
   // File register read
   output wire logic [FADDR_W-1:0]  FILE_RADDR,
   input  wire logic [DATA_W-1:0]   FILE_RDATA,
   // File register write-back
   output wire logic                FILE_WE,
   output wire logic [FADDR_W-1:0]  FILE_WADDR,
   output wire logic [DATA_W-1:0]   FILE_WDATA,
   // Working register
   input  wire logic                W_LOAD,
   input  wire logic [DATA_W-1:0]   W_LOAD_DATA,
   output wire logic [DATA_W-1:0]   W_OUT,
   // Zero flag update
   output wire logic                Z_WE,
   output wire logic                Z_VAL,
   // Direction registers
   output wire logic [DATA_W-1:0]   DIR_PORT_A,
   output wire logic [DATA_W-1:0]   DIR_PORT_B,
   output wire logic [DATA_W-1:0]   SECOND_OPTION_REGISTER_OUT,
   // Status of the step
   output wire logic                EXEC_DONE,
   output wire logic                EXEC_IGNORED
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic logic op_hit(input logic [11:0] ins, input logic [11:0] mask, input logic [11:0] match);
      op_hit = ((ins & mask) == match);
   endfunction : op_hit

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == ZERO_BYTE);
   endfunction : is_zero

   wire               nibble_swap_op;
   wire               register_xor_op;
   wire               literal_xor_op;
   wire               direction_load_op;
   wire               dsel_ok;
   wire               dest_bit;
   wire [FADDR_W-1:0] faddr;
   wire [DATA_W-1:0]  literal;
   wire [DSEL_W-1:0]  dsel;

   assign nibble_swap_op    = INSTR_VALID && op_hit(INSTR, SWAP_MASK, SWAP_MATCH);
   assign register_xor_op   = INSTR_VALID && op_hit(INSTR, RXOR_MASK, RXOR_MATCH);
   assign literal_xor_op    = INSTR_VALID && op_hit(INSTR, LXOR_MASK, LXOR_MATCH);
   assign dsel              = INSTR[DSEL_LO +: DSEL_W];
   // Selectors below 5 are not direction registers; the word is treated as not ours
   assign dsel_ok           = (dsel == SEL_PORT_A) || (dsel == SEL_PORT_B) || (dsel == SEL_SECOND_OPTION_REGISTER);
   assign direction_load_op = INSTR_VALID && op_hit(INSTR, DLD_MASK, DLD_MATCH) && dsel_ok;
   assign dest_bit          = INSTR[DEST_BIT];
   assign faddr             = INSTR[FADDR_LO +: FADDR_W];
   assign literal           = INSTR[LIT_LO +: DATA_W];

   assign FILE_RADDR = faddr;

   ////////////////////////////////////////////////////////////////////////////
   // Datapath

   logic [DATA_W-1:0] w_r;
   logic [DATA_W-1:0] w_nxt;
   logic              file_we_r;
   logic              file_we_nxt;
   logic [FADDR_W-1:0] file_waddr_r;
   logic [DATA_W-1:0] file_wdata_r;
   logic [DATA_W-1:0] file_wdata_nxt;
   logic              z_we_r;
   logic              z_we_nxt;
   logic              z_val_r;
   logic              z_val_nxt;
   logic              done_r;
   logic              ign_r;

   wire [DATA_W-1:0]  swap_res;
   wire [DATA_W-1:0]  rxor_res;
   wire [DATA_W-1:0]  lxor_res;
   wire               to_file;
   wire               to_w;
   wire               known_op;

   assign swap_res = {FILE_RDATA[3:0], FILE_RDATA[7:4]};
   assign rxor_res = w_r ^ FILE_RDATA;
   assign lxor_res = w_r ^ literal;

   assign to_file  = (nibble_swap_op || register_xor_op) && (dest_bit == DEST_FILE);
   assign to_w     = ((nibble_swap_op || register_xor_op) && (dest_bit == DEST_W))
                     || literal_xor_op;
   assign known_op = nibble_swap_op || register_xor_op || literal_xor_op || direction_load_op;

   always_comb
   begin
      file_wdata_nxt = file_wdata_r;
      if (nibble_swap_op)
         file_wdata_nxt = swap_res;
      else if (register_xor_op)
         file_wdata_nxt = rxor_res;
   end

   always_comb
   begin
      w_nxt = w_r;
      // Our own result wins over an outside load presented in the same cycle
      if (W_LOAD)
         w_nxt = W_LOAD_DATA;
      if (to_w && nibble_swap_op)
         w_nxt = swap_res;
      else if (to_w && register_xor_op)
         w_nxt = rxor_res;
      else if (literal_xor_op)
         w_nxt = lxor_res;
   end

   // Swap and direction load leave the zero flag alone; only the xor forms touch it
   assign file_we_nxt = to_file;
   assign z_we_nxt    = register_xor_op || literal_xor_op;
   assign z_val_nxt   = register_xor_op ? is_zero(rxor_res) : is_zero(lxor_res);

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
         w_r <= W_RST;
      else
         w_r <= w_nxt;
   end

   // Address holds after a write, and data until the next swap or register xor, so the file side may sample them late
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         file_we_r    <= 1'b0;
         file_waddr_r <= '0;
         file_wdata_r <= ZERO_BYTE;
      end
      else
      begin
         file_we_r    <= file_we_nxt;
         file_waddr_r <= to_file ? faddr : file_waddr_r;
         file_wdata_r <= file_wdata_nxt;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         z_we_r  <= 1'b0;
         z_val_r <= 1'b0;
      end
      else
      begin
         z_we_r  <= z_we_nxt;
         z_val_r <= z_we_nxt ? z_val_nxt : z_val_r;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         done_r <= 1'b0;
         ign_r  <= 1'b0;
      end
      else
      begin
         done_r <= known_op;
         ign_r  <= INSTR_VALID && !known_op;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Direction registers

   nsx_dir_if dif ();

   // W is the value before this instruction, as the load reads W, not a result
   assign dif.ld   = direction_load_op;
   assign dif.sel  = dsel;
   assign dif.data = w_r;

   nsx_dir_bank u_bank
   (
      .clk (REF_CLK),
      .rst (SYS_RST),
      .dif (dif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign FILE_WE      = file_we_r;
   assign FILE_WADDR   = file_waddr_r;
   assign FILE_WDATA   = file_wdata_r;
   assign W_OUT        = w_r;
   assign Z_WE         = z_we_r;
   assign Z_VAL        = z_val_r;
   assign DIR_PORT_A   = dif.dir_a;
   assign DIR_PORT_B   = dif.dir_b;
   assign SECOND_OPTION_REGISTER_OUT  = dif.opt2;
   assign EXEC_DONE    = done_r;
   assign EXEC_IGNORED = ign_r;

endmodule : nsx_exec

// >>> core/nsx_pkg.sv
// Purpose: Shared constants for the nibble swap / xor / direction-load execute block
// Assumes: 12-bit instruction words, 8-bit data, 5-bit file register address
// Notes:   Opcode matching is done with mask/match pairs
package nsx_pkg;

   localparam int INSTR_W = 12;
   localparam int DATA_W  = 8;
   localparam int FADDR_W = 5;
   localparam int DSEL_W  = 3;

   // Opcode mask and match pairs
   localparam logic [11:0] SWAP_MASK  = 12'h0FC0;
   localparam logic [11:0] SWAP_MATCH = 12'h0380;
   localparam logic [11:0] RXOR_MASK  = 12'h0FC0;
   localparam logic [11:0] RXOR_MATCH = 12'h0180;
   localparam logic [11:0] DLD_MASK   = 12'h0FF8;
   localparam logic [11:0] DLD_MATCH  = 12'h0000;
   localparam logic [11:0] LXOR_MASK  = 12'h0F00;
   localparam logic [11:0] LXOR_MATCH = 12'h0F00;

   // Field positions
   localparam int DEST_BIT = 5;
   localparam int FADDR_LO = 0;
   localparam int LIT_LO   = 0;
   localparam int DSEL_LO  = 0;

   // Destination bit values
   localparam logic DEST_W    = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // Direction-load selectors
   localparam logic [2:0] SEL_PORT_A  = 3'h5;
   localparam logic [2:0] SEL_PORT_B  = 3'h6;
   localparam logic [2:0] SEL_SECOND_OPTION_REGISTER = 3'h7;

   // Values after reset
   localparam logic [7:0] W_RST     = 8'h00;
   localparam logic [7:0] DIR_RST   = 8'hFF;
   localparam logic [7:0] OPT2_RST  = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

endpackage : nsx_pkg

// >>> verif/nsx_exec_assertions.sv
// Purpose: Port-level checks of the execute block
// Assumes: One clock, synchronous active-high reset
// Notes:   Results are judged one edge after the instruction is taken
`timescale 1ns/1ps
module nsx_exec_chk
   import nsx_pkg::*;
(
   // Clock and reset
   input wire logic        REF_CLK,
   input wire logic        SYS_RST,
   // Instruction and file read
   input wire logic [11:0] INSTR,
   input wire logic        INSTR_VALID,
   input wire logic [7:0]  FILE_RDATA,
   // Results
   input wire logic        FILE_WE,
   input wire logic [4:0]  FILE_WADDR,
   input wire logic [7:0]  FILE_WDATA,
   input wire logic [7:0]  W_OUT,
   input wire logic        Z_WE,
   input wire logic        Z_VAL,
   input wire logic [7:0]  DIR_PORT_A,
   input wire logic [7:0]  DIR_PORT_B,
   input wire logic [7:0]  SECOND_OPTION_REGISTER_OUT
);
   wire logic       sw  = INSTR_VALID && ((INSTR & SWAP_MASK) == SWAP_MATCH);
   wire logic       rx  = INSTR_VALID && ((INSTR & RXOR_MASK) == RXOR_MATCH);
   wire logic       lx  = INSTR_VALID && ((INSTR & LXOR_MASK) == LXOR_MATCH);
   wire logic       dl  = INSTR_VALID && ((INSTR & DLD_MASK) == DLD_MATCH);
   wire logic [7:0] swp = {FILE_RDATA[3:0], FILE_RDATA[7:4]};
   wire logic [7:0] rxv = W_OUT ^ FILE_RDATA;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   a_swap_to_w: assert property (
      sw && !INSTR[5] |=> W_OUT == $past(swp) && !Z_WE && !FILE_WE) else $error("swap to w wrong");
   a_swap_to_file: assert property (
      sw && INSTR[5] |=> FILE_WE && FILE_WADDR == $past(INSTR[4:0]) && FILE_WDATA == $past(swp) && !Z_WE)
      else $error("swap to file wrong");
   a_rxor_to_w: assert property (
      rx && !INSTR[5] |=> W_OUT == $past(rxv) && Z_WE && Z_VAL == (W_OUT == 8'h00) && !FILE_WE)
      else $error("xor to w wrong");
   a_rxor_to_file: assert property (
      rx && INSTR[5] |=> FILE_WE && FILE_WDATA == $past(rxv) && Z_WE && Z_VAL == (FILE_WDATA == 8'h00))
      else $error("xor to file wrong");
   a_lxor_to_w: assert property (
      lx |=> W_OUT == $past(W_OUT ^ INSTR[7:0]) && Z_WE && Z_VAL == (W_OUT == 8'h00) && !FILE_WE)
      else $error("literal xor wrong");
   a_dir_port_a: assert property (
      dl && INSTR[2:0] == SEL_PORT_A |=> DIR_PORT_A == $past(W_OUT) && !Z_WE && !FILE_WE)
      else $error("direction load wrong");
   a_dir_port_b: assert property (
      dl && INSTR[2:0] == SEL_PORT_B |=> DIR_PORT_B == $past(W_OUT) && $stable(DIR_PORT_A) && !Z_WE && !FILE_WE)
      else $error("direction load b wrong");
   a_dir_ignored: assert property (
      dl && INSTR[2:0] < SEL_PORT_A |=> $stable(DIR_PORT_A) && $stable(DIR_PORT_B) && $stable(SECOND_OPTION_REGISTER_OUT) && !Z_WE)
      else $error("ignored direction load changed state");
   a_opt2_load: assert property (
      dl && INSTR[2:0] == SEL_SECOND_OPTION_REGISTER |=> SECOND_OPTION_REGISTER_OUT == $past(W_OUT) && $stable(DIR_PORT_A) && $stable(DIR_PORT_B))
      else $error("option load wrong");
   a_zero_cause: assert property (
      Z_WE |-> $past(rx || lx)) else $error("zero update without xor");
endmodule : nsx_exec_chk
bind nsx_exec nsx_exec_chk u_nsx_exec_chk (.REF_CLK, .SYS_RST, .INSTR, .INSTR_VALID, .FILE_RDATA, .FILE_WE,
   .FILE_WADDR, .FILE_WDATA, .W_OUT, .Z_WE, .Z_VAL, .DIR_PORT_A, .DIR_PORT_B, .SECOND_OPTION_REGISTER_OUT);

// >>> verif/nsx_exec_test.sv
// Purpose: Directed bench for the execute block
// Assumes: One instruction per issue call, results read just after the taking edge
// Notes:   W is preset through the load port
`timescale 1ns/1ps
module nsx_exec_test;
   logic       ref_clk, sys_rst, instr_valid, w_load, file_we, z_we, z_val, done, ign;
   logic [11:0] instr;
   logic [7:0]  w_load_data, rdata, wdata, w_out, dir_a, dir_b, opt2;
   logic [4:0]  raddr, waddr;
   int          bad_count, cmp_count;
   nsx_exec u_nsx_exec (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .INSTR(instr), .INSTR_VALID(instr_valid),
      .FILE_RADDR(raddr), .FILE_RDATA(rdata), .FILE_WE(file_we), .FILE_WADDR(waddr), .FILE_WDATA(wdata),
      .W_LOAD(w_load), .W_LOAD_DATA(w_load_data), .W_OUT(w_out), .Z_WE(z_we), .Z_VAL(z_val),
      .DIR_PORT_A(dir_a), .DIR_PORT_B(dir_b), .SECOND_OPTION_REGISTER_OUT(opt2), .EXEC_DONE(done), .EXEC_IGNORED(ign));
   nsx_file_model u_nsx_file_model (.clk(ref_clk), .raddr(raddr), .rdata(rdata), .we(file_we),
      .waddr(waddr), .wdata(wdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic set_w(input logic [7:0] v);
      @(posedge ref_clk);
      w_load      <= 1'b1;
      w_load_data <= v;
      @(posedge ref_clk);
      w_load      <= 1'b0;
   endtask : set_w
   // Gap cycle between issues keeps each drive to one assignment per edge
   task automatic issue(input logic [11:0] i);
      @(posedge ref_clk);
      instr       <= i;
      instr_valid <= 1'b1;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1;
   endtask : issue
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_swap;
      u_nsx_file_model.mem[3] = 8'hA5;
      set_w(8'h11);
      issue(12'h0383);
      check(w_out, 8'h5A);
      check({5'h00, z_we, file_we, done}, 8'h01);
      issue(12'h03A3);
      check(wdata, 8'h5A);
      check({1'b0, z_we, file_we, waddr}, 8'h23);
      check(w_out, 8'h5A);
      $display("swap test done");
   endtask : t_swap
   task automatic t_xor;
      u_nsx_file_model.mem[4] = 8'hAF;
      set_w(8'hB5);
      issue(12'h01A4);
      check(wdata, 8'h1A);
      check({1'b0, z_we, z_val, waddr}, 8'h44);
      check(w_out, 8'hB5);
      issue(12'h0184);
      check(w_out, 8'hAF);
      check({6'h00, z_we, file_we}, 8'h02);
      issue(12'h0FAF);
      check(w_out, 8'h00);
      check({6'h00, z_we, z_val}, 8'h03);
      $display("xor test done");
   endtask : t_xor
   task automatic t_dir;
      check(dir_a, 8'hFF);
      check(dir_b, 8'hFF);
      check(opt2, 8'hFF);
      set_w(8'hA5);
      issue(12'h0005);
      check(dir_a, 8'hA5);
      check({6'h00, z_we, file_we}, 8'h00);
      set_w(8'h3C);
      issue(12'h0006);
      check(dir_b, 8'h3C);
      set_w(8'hC3);
      issue(12'h0007);
      check(opt2, 8'hC3);
      check(dir_b ^ dir_a, 8'h99);
      issue(12'h0004);
      check({6'h00, ign, done}, 8'h02);
      check(dir_a, 8'hA5);
      $display("direction test done");
   endtask : t_dir
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial
   begin
      #20000;
      bad_count++;
      complete_run();
   end
   initial
   begin
      sys_rst = 1'b1;
      instr_valid = 1'b0;
      w_load = 1'b0;
      instr = 12'h0000;
      w_load_data = 8'h00;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1;
      check(w_out, 8'h00);
      t_dir();
      t_swap();
      t_xor();
      complete_run();
   end
endmodule : nsx_exec_test

// >>> verif/nsx_file_model.sv
// Purpose: File register array beside the execute block
// Assumes: Read is combinational, write lands at the edge after the request
// Notes:   No forwarding, so a write-back is seen one instruction later
`timescale 1ns/1ps
module nsx_file_model
   import nsx_pkg::*;
(
   // Clock
   input  wire logic         clk,
   // Access
   input  wire logic [4:0]   raddr,
   output logic [7:0]        rdata,
   input  wire logic         we,
   input  wire logic [4:0]   waddr,
   input  wire logic [7:0]   wdata
);
   logic [7:0] mem [0:31];
   assign rdata = mem[raddr];
   always @(posedge clk)
   begin
      if (we)
         mem[waddr] <= wdata;
   end
endmodule : nsx_file_model
